// [logic/dtl_command_core.sv]
`timescale 1ns/1ns
// Contract
// - Default dwell survives reset command; accepts 00.01 to 99.99 s.
// - Default dwell query answers name and value in 10 characters.
// - Trigger function is not part of the saved settings.
// - Trigger choices: off, output, step recall, sequence run, lock, min-max.
// - Lock choice disables panel and lights the locked/sequence indicator.
// - Recall/run trigger while uninitialised: error shown 1 s, sequence fault bit 5.
// - Recall and run triggers act only once the sequence is initialised.
// - Trigger query answers name and choice in 10 characters.
// - Per-location dwell reads 00.00 after reset, meaning default applies.
// - Per-location dwell query answers nn.nn in 10 characters; 10 ms steps.
// - Limit below present setpoint is refused and not executed.
// - Refused limit or setpoint sets limit bit 1 and execution bit 4.
// - Limit rounds to nearest 1 mV step.
// - Displayed limit rounds again to four places.
// - Limit does not constrain the analog-interface setpoint.
// - Limit query answers +nnn.nnn in 13 characters.
// - Peak voltage query answers +nnn.nnn in 13 characters.
// - Floor voltage query answers +nnn.nnn in 13 characters.
// - Out-of-range parameter raises command error.
module dtl_command_core
  import dtl_pkg::*;
#(
  parameter logic [19:0] LIMIT_MAX_MV = 20'h04e20,
  parameter int unsigned ERR_SHOW_LEN = ERR_SHOW_CYCLES
) (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic [31:0] wb_dat_o, // Wishbone read data
  input wire logic trigPin, // Trigger input pin
  input wire logic analogModePin, // Analog setpoint control pin
  input wire logic [19:0] analogSetpointMv, // Analog setpoint, same clock
  input wire logic signed [19:0] measVoltMv, // Measured voltage, same clock
  input wire logic seqInitDone, // Sequence engine initialised
  input wire logic seqBusy, // Sequence engine running
  output logic panelLocked, // Front panel disabled
  output logic lockLed, // Locked/sequence indicator
  output logic outputOn, // Output on/off from trigger
  output logic recallStep, // Step recall pulse
  output logic seqStart, // Sequence start pulse
  output logic errShow, // Error code displayed
  output logic [7:0] errCode, // Displayed error code
  output logic [19:0] voltSetpointMv, // Setpoint to power stage
  output logic [19:0] limitDisplayMv // Limit as displayed
);

  // ==========================================================================
  // Elaboration checks
  if (LIMIT_MAX_MV == 20'h00000) begin : g_badLimit
    $error("Limit maximum must be above zero");
  end
  if (ERR_SHOW_LEN < 1 || ERR_SHOW_LEN > 32'h7fff_ffff) begin : g_badShow
    $error("Error display length out of range");
  end

  // ==========================================================================
  // Formatting helpers
  function automatic logic [47:0] dec6(input logic [19:0] v);
    logic [19:0] t;
    begin
      t = v;
      dec6 = '0;
      for (int i = 0; i < 6; i++) begin
        dec6[i*8 +: 8] = 8'h30 + 8'(t % 20'd10);
        t = t / 20'd10;
      end
    end
  endfunction

  function automatic logic [103:0] voltText(input logic [31:0] name, input logic signed [19:0] v);
    logic [19:0] mag;
    logic [47:0] d;
    begin
      mag = v[19] ? 20'(-v) : 20'(v);
      d = dec6(mag);
      voltText = {name, 8'h20, (v[19] ? 8'h2d : 8'h2b), d[47:24], 8'h2e, d[23:0]};
    end
  endfunction

  function automatic logic [79:0] dwellText(input logic [31:0] name, input logic [13:0] v);
    logic [47:0] d;
    begin
      d = dec6({6'h00, v});
      dwellText = {name, 8'h20, d[31:16], 8'h2e, d[15:0]};
    end
  endfunction

  function automatic logic [31:0] laneMask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [19:0] dispRound(input logic [19:0] mv);
    logic [20:0] t;
    begin
      if (mv >= DISP_COARSE_MV) begin
        t = 21'(((21'(mv) + 21'd50) / 21'd100) * 21'd100);
      end else if (mv >= DISP_MID_MV) begin
        t = 21'(((21'(mv) + 21'd5) / 21'd10) * 21'd10);
      end else begin
        t = 21'(mv);
      end
      dispRound = t[19:0];
    end
  endfunction

  // ==========================================================================
  // State
  logic ackReg, ackNext;
  logic [31:0] datReg, datNext;
  logic [31:0] argReg, argNext;
  dtl_settings_t liveReg, liveNext;
  dtl_settings_t savedReg, savedNext;
  dtl_trig_t trigModeReg, trigModeNext;
  logic [19:0] setptReg, setptNext;
  logic [19:0] dispReg, dispNext;
  logic [7:0] evbReg, evbNext;
  logic [7:0] stdReg, stdNext;
  logic [103:0] respReg, respNext;
  logic [3:0] respCntReg, respCntNext;
  logic signed [19:0] peakReg, peakNext;
  logic signed [19:0] floorReg, floorNext;
  logic [31:0] errCntReg, errCntNext;
  logic trigSync1Reg, trigSync2Reg, trigPrevReg;
  logic anaSync1Reg, anaSync2Reg;
  logic lockReg, lockNext;
  logic ledReg, ledNext;
  logic outOnReg, outOnNext;
  logic recallReg, recallNext;
  logic seqStartReg, seqStartNext;
  logic showReg, showNext;
  logic [7:0] codeReg, codeNext;
  logic [19:0] vsetReg, vsetNext;

  logic accept, wrAccept, rdAccept, trigEdge;
  logic [31:0] wdata, mask;
  logic [31:0] roundedMv;
  logic [7:0] evbSet, stdSet, evbClr, stdClr;
  logic [23:0] choiceText;
  dtl_op_t op;

  always_comb begin
    accept = wb_cyc_i && wb_stb_i && !ackReg;
    wrAccept = accept && wb_we_i;
    rdAccept = accept && !wb_we_i;
    mask = laneMask(wb_sel_i);
    wdata = wb_dat_i & mask;
    trigEdge = trigSync2Reg && !trigPrevReg;
    // Nearest 1 mV step from a microvolt argument
    roundedMv = (argReg + UV_HALF_STEP) / UV_PER_MV;
    op = dtl_op_t'(wdata[3:0]);
    unique case (trigModeReg)
      TM_OFF: choiceText = TXT_CH_OFF;
      TM_OUTPUT: choiceText = TXT_CH_OUT;
      TM_RECALL: choiceText = TXT_CH_RECALL;
      TM_SEQRUN: choiceText = TXT_CH_SEQRUN;
      TM_PANEL_LOCK: choiceText = TXT_CH_LOCK;
      TM_MINMAX: choiceText = TXT_CH_MINMAX;
      default: choiceText = TXT_CH_OFF;
    endcase

    ackNext = accept;
    datNext = '0;
    argNext = argReg;
    liveNext = liveReg;
    savedNext = savedReg;
    trigModeNext = trigModeReg;
    setptNext = setptReg;
    dispNext = dispReg;
    respNext = respReg;
    respCntNext = respCntReg;
    errCntNext = errCntReg;
    evbSet = '0;
    stdSet = '0;
    evbClr = '0;
    stdClr = '0;
    outOnNext = outOnReg;
    recallNext = 1'b0;
    seqStartNext = 1'b0;

    // ========================================================================
    // Register reads; unmapped addresses answer zero
    if (rdAccept) begin
      unique case (wb_adr_i)
        OFS_ARG: datNext = argReg;
        OFS_STATUS: datNext = {20'h00000, seqInitDone, lockReg, trigModeReg, 1'b0, respCntReg, 2'b00};
        OFS_EVB: datNext = {24'h000000, evbReg};
        OFS_STDEV: datNext = {24'h000000, stdReg};
        OFS_RESP: begin
          // Each read hands out the next response character
          if (respCntReg != 4'h0) begin
            datNext = {24'h000000, respReg[103:96]};
            respNext = {respReg[95:0], 8'h00};
            respCntNext = respCntReg - 4'h1;
          end
        end
        OFS_SETPT: datNext = {12'h000, setptReg};
        OFS_LIMIT: datNext = {12'h000, liveReg.limitMv};
        OFS_DISP: datNext = {12'h000, dispReg};
        OFS_DWELL: datNext = {2'b00, liveReg.dwellDef, 2'b00, liveReg.dwellLoc};
        OFS_SAVED: datNext = {2'b00, savedReg.dwellLoc, 16'h0000} | {12'h000, savedReg.limitMv};
        OFS_PEAK: datNext = 32'(peakReg);
        OFS_FLOOR: datNext = 32'(floorReg);
        default: datNext = '0;
      endcase
    end

    // ========================================================================
    // Register writes and command execution
    if (wrAccept) begin
      unique case (wb_adr_i)
        OFS_ARG: argNext = (argReg & ~mask) | wdata;
        OFS_EVB: evbClr = wdata[7:0];
        OFS_STDEV: stdClr = wdata[7:0];
        OFS_CMD: begin
          if (wb_sel_i[0]) begin
            unique case (op)
              OP_NOP: ;
              OP_SET_DWELL_DEF: begin
                if (argReg >= 32'(DWELL_MIN) && argReg <= 32'(DWELL_MAX)) begin
                  liveNext.dwellDef = argReg[13:0];
                end else begin
                  stdSet[STD_CME_BIT] = 1'b1;
                end
              end
              OP_Q_DWELL_DEF: begin
                respNext = {dwellText(TXT_DWELL_DEF, liveReg.dwellDef), 24'h000000};
                respCntNext = RESP_SHORT;
              end
              OP_SET_TRIG: begin
                if (argReg <= 32'(TM_MINMAX)) begin
                  trigModeNext = dtl_trig_t'(argReg[2:0]);
                end else begin
                  stdSet[STD_CME_BIT] = 1'b1;
                end
              end
              OP_Q_TRIG: begin
                respNext = {TXT_TRIG, 8'h20, choiceText, 24'h000000};
                respCntNext = RESP_SHORT;
              end
              OP_SET_DWELL_LOC: begin
                if (argReg >= 32'(DWELL_MIN) && argReg <= 32'(DWELL_MAX)) begin
                  liveNext.dwellLoc = argReg[13:0];
                end else begin
                  stdSet[STD_CME_BIT] = 1'b1;
                end
              end
              OP_Q_DWELL_LOC: begin
                respNext = {dwellText(TXT_DWELL_LOC, liveReg.dwellLoc), 24'h000000};
                respCntNext = RESP_SHORT;
              end
              OP_SET_LIMIT: begin
                if (argReg[31] || roundedMv > 32'(LIMIT_MAX_MV)) begin
                  stdSet[STD_CME_BIT] = 1'b1;
                end else if (roundedMv[19:0] < setptReg) begin
                  evbSet[EVB_LIMIT_BIT] = 1'b1;
                  stdSet[STD_EXE_BIT] = 1'b1;
                end else begin
                  liveNext.limitMv = roundedMv[19:0];
                  dispNext = dispRound(roundedMv[19:0]);
                end
              end
              OP_Q_LIMIT: begin
                respNext = voltText(TXT_LIMIT, $signed(liveReg.limitMv));
                respCntNext = RESP_LONG;
              end
              OP_Q_PEAK: begin
                respNext = voltText(TXT_PEAK, peakReg);
                respCntNext = RESP_LONG;
              end
              OP_Q_FLOOR: begin
                respNext = voltText(TXT_FLOOR, floorReg);
                respCntNext = RESP_LONG;
              end
              OP_SET_POINT: begin
                if (argReg[31] || roundedMv > 32'(LIMIT_MAX_MV)) begin
                  stdSet[STD_CME_BIT] = 1'b1;
                end else if (roundedMv[19:0] > liveReg.limitMv) begin
                  evbSet[EVB_LIMIT_BIT] = 1'b1;
                  stdSet[STD_EXE_BIT] = 1'b1;
                end else begin
                  setptNext = roundedMv[19:0];
                end
              end
              OP_RESET: begin
                // Default dwell and trigger choice are left as they are
                liveNext.dwellLoc = DWELL_LOC_RST;
                liveNext.limitMv = LIMIT_MAX_MV;
                dispNext = dispRound(LIMIT_MAX_MV);
                setptNext = SETPT_RST;
              end
              OP_SAVE: savedNext = liveReg;
              default: stdSet[STD_CME_BIT] = 1'b1;
            endcase
          end
        end
        default: ;
      endcase
    end

    // ========================================================================
    // Trigger input actions
    if (trigEdge) begin
      unique case (trigModeReg)
        TM_OUTPUT: outOnNext = !outOnReg;
        TM_RECALL, TM_SEQRUN: begin
          if (seqInitDone) begin
            recallNext = (trigModeReg == TM_RECALL);
            seqStartNext = (trigModeReg == TM_SEQRUN);
          end else begin
            evbSet[EVB_SEQ_BIT] = 1'b1;
            errCntNext = ERR_SHOW_LEN;
          end
        end
        default: ;
      endcase
    end else if (errCntReg != 32'h0000_0000) begin
      errCntNext = errCntReg - 32'h0000_0001;
    end
    showNext = (errCntNext != 32'h0000_0000);
    codeNext = showNext ? ERR_CODE_SEQ : 8'h00;

    // A hardware event in the same cycle as its clear is kept
    evbNext = (evbReg & ~evbClr) | evbSet;
    stdNext = (stdReg & ~stdClr) | stdSet;

    lockNext = (trigModeReg == TM_PANEL_LOCK);
    ledNext = (trigModeReg == TM_PANEL_LOCK) || seqBusy;
    // Analog control bypasses the limit check altogether
    vsetNext = anaSync2Reg ? analogSetpointMv : setptReg;

    // Extremes track unless min-max control gates them with the trigger level
    peakNext = peakReg;
    floorNext = floorReg;
    if (trigModeReg != TM_MINMAX || trigSync2Reg) begin
      if (measVoltMv > peakReg) begin
        peakNext = measVoltMv;
      end
      if (measVoltMv < floorReg) begin
        floorNext = measVoltMv;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ackReg <= 1'b0;
      datReg <= '0;
      argReg <= '0;
      liveReg <= '{dwellDef: DWELL_DEF_RST, dwellLoc: DWELL_LOC_RST, limitMv: LIMIT_MAX_MV};
      savedReg <= '{dwellDef: DWELL_DEF_RST, dwellLoc: DWELL_LOC_RST, limitMv: LIMIT_MAX_MV};
      trigModeReg <= TM_OFF;
      setptReg <= SETPT_RST;
      dispReg <= LIMIT_MAX_MV;
      evbReg <= '0;
      stdReg <= '0;
      respReg <= '0;
      respCntReg <= 4'h0;
      peakReg <= PEAK_RST;
      floorReg <= FLOOR_RST;
      errCntReg <= '0;
      trigSync1Reg <= 1'b0;
      trigSync2Reg <= 1'b0;
      trigPrevReg <= 1'b0;
      anaSync1Reg <= 1'b0;
      anaSync2Reg <= 1'b0;
      lockReg <= 1'b0;
      ledReg <= 1'b0;
      outOnReg <= 1'b0;
      recallReg <= 1'b0;
      seqStartReg <= 1'b0;
      showReg <= 1'b0;
      codeReg <= 8'h00;
      vsetReg <= SETPT_RST;
    end else begin
      ackReg <= ackNext;
      datReg <= datNext;
      argReg <= argNext;
      liveReg <= liveNext;
      savedReg <= savedNext;
      trigModeReg <= trigModeNext;
      setptReg <= setptNext;
      dispReg <= dispNext;
      evbReg <= evbNext;
      stdReg <= stdNext;
      respReg <= respNext;
      respCntReg <= respCntNext;
      peakReg <= peakNext;
      floorReg <= floorNext;
      errCntReg <= errCntNext;
      trigSync1Reg <= trigPin;
      trigSync2Reg <= trigSync1Reg;
      trigPrevReg <= trigSync2Reg;
      anaSync1Reg <= analogModePin;
      anaSync2Reg <= anaSync1Reg;
      lockReg <= lockNext;
      ledReg <= ledNext;
      outOnReg <= outOnNext;
      recallReg <= recallNext;
      seqStartReg <= seqStartNext;
      showReg <= showNext;
      codeReg <= codeNext;
      vsetReg <= vsetNext;
    end
  end

  assign wb_ack_o = ackReg;
  assign wb_dat_o = datReg;
  assign panelLocked = lockReg;
  assign lockLed = ledReg;
  assign outputOn = outOnReg;
  assign recallStep = recallReg;
  assign seqStart = seqStartReg;
  assign errShow = showReg;
  assign errCode = codeReg;
  assign voltSetpointMv = vsetReg;
  assign limitDisplayMv = dispReg;

endmodule

// [pkg/dtl_pkg.sv]
package dtl_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ERR_SHOW_MS = 1000;
  localparam int unsigned ERR_SHOW_CYCLES = (CLK_HZ / 1000) * ERR_SHOW_MS;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ARG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_EVB = 8'h0c;
  localparam logic [7:0] OFS_STDEV = 8'h10;
  localparam logic [7:0] OFS_RESP = 8'h14;
  localparam logic [7:0] OFS_SETPT = 8'h18;
  localparam logic [7:0] OFS_LIMIT = 8'h1c;
  localparam logic [7:0] OFS_DISP = 8'h20;
  localparam logic [7:0] OFS_DWELL = 8'h24;
  localparam logic [7:0] OFS_SAVED = 8'h28;
  localparam logic [7:0] OFS_PEAK = 8'h2c;
  localparam logic [7:0] OFS_FLOOR = 8'h30;

  // ==========================================================================
  // Event bit positions
  localparam int unsigned EVB_LIMIT_BIT = 1;
  localparam int unsigned EVB_SEQ_BIT = 5;
  localparam int unsigned STD_EXE_BIT = 4;
  localparam int unsigned STD_CME_BIT = 5;

  // ==========================================================================
  // Ranges, steps and reset values (dwell in 10 ms units, voltage in mV, rounding step in uV)
  localparam logic [13:0] DWELL_MIN = 14'h0001;
  localparam logic [13:0] DWELL_MAX = 14'h270f;
  localparam logic [13:0] DWELL_DEF_RST = 14'h0064;
  localparam logic [13:0] DWELL_LOC_RST = 14'h0000;
  localparam logic [31:0] UV_PER_MV = 32'h0000_03e8;
  localparam logic [31:0] UV_HALF_STEP = 32'h0000_01f4;
  localparam logic [19:0] DISP_COARSE_MV = 20'h186a0;
  localparam logic [19:0] DISP_MID_MV = 20'h02710;
  localparam logic [19:0] SETPT_RST = 20'h00000;
  localparam logic signed [19:0] PEAK_RST = 20'sh80000;
  localparam logic signed [19:0] FLOOR_RST = 20'sh7ffff;
  localparam logic [7:0] ERR_CODE_SEQ = 8'h1b;
  localparam logic [3:0] RESP_SHORT = 4'ha;
  localparam logic [3:0] RESP_LONG = 4'hd;

  // ==========================================================================
  // Response text pieces (ASCII)
  localparam logic [31:0] TXT_DWELL_DEF = 32'h5444_4546;
  localparam logic [31:0] TXT_DWELL_LOC = 32'h5453_4554;
  localparam logic [31:0] TXT_LIMIT = 32'h554c_494d;
  localparam logic [31:0] TXT_PEAK = 32'h554d_4158;
  localparam logic [31:0] TXT_FLOOR = 32'h554d_494e;
  localparam logic [47:0] TXT_TRIG = 48'h545f_4d4f_4445;
  localparam logic [23:0] TXT_CH_OFF = 24'h4f4646;
  localparam logic [23:0] TXT_CH_OUT = 24'h4f5554;
  localparam logic [23:0] TXT_CH_RECALL = 24'h52434c;
  localparam logic [23:0] TXT_CH_SEQRUN = 24'h534551;
  localparam logic [23:0] TXT_CH_LOCK = 24'h4c4c4f;
  localparam logic [23:0] TXT_CH_MINMAX = 24'h4d494e;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    OP_NOP, OP_SET_DWELL_DEF, OP_Q_DWELL_DEF, OP_SET_TRIG, OP_Q_TRIG,
    OP_SET_DWELL_LOC, OP_Q_DWELL_LOC, OP_SET_LIMIT, OP_Q_LIMIT, OP_Q_PEAK,
    OP_Q_FLOOR, OP_SET_POINT, OP_RESET, OP_SAVE
  } dtl_op_t;

  typedef enum logic [2:0] {
    TM_OFF, TM_OUTPUT, TM_RECALL, TM_SEQRUN, TM_PANEL_LOCK, TM_MINMAX
  } dtl_trig_t;

  typedef struct packed {
    logic [13:0] dwellDef;
    logic [13:0] dwellLoc;
    logic [19:0] limitMv;
  } dtl_settings_t;

endpackage

// [verification/dtl_command_core_properties.sv]
`timescale 1ns/1ns
module dtl_command_core_properties
  import dtl_pkg::*;
#(
  parameter int unsigned ERR_SHOW_LEN = 20
) (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_ack_o, // Bus acknowledge
  input wire logic [31:0] wb_dat_o, // Bus read data
  input wire logic seqInitDone, // Sequence ready
  input wire logic panelLocked, // Panel disabled
  input wire logic lockLed, // Lock indicator
  input wire logic recallStep, // Recall pulse
  input wire logic seqStart, // Run pulse
  input wire logic errShow, // Error shown
  input wire logic [7:0] errCode // Shown code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Error display length counter
  logic [31:0] errCnt_reg, errCnt_next;
  always_comb begin
    errCnt_next = errShow ? errCnt_reg + 32'h1 : 32'h0;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) errCnt_reg <= 32'h0;
    else errCnt_reg <= errCnt_next;
  end
  // ==========================================================
  // Properties
  ack_answers_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  lock_led_a: assert property (panelLocked |-> lockLed) else $error("lock without led");
  recall_init_a: assert property (recallStep |-> seqInitDone ##1 !recallStep) else $error("bad recall");
  run_init_a: assert property (seqStart |-> seqInitDone ##1 !seqStart) else $error("bad run start");
  err_code_a: assert property (errCode == (errShow ? ERR_CODE_SEQ : 8'h00)) else $error("bad code");
  err_span_a: assert property ($fell(errShow) |-> errCnt_reg == ERR_SHOW_LEN) else $error("bad span");
endmodule

bind dtl_command_core dtl_command_core_properties #(.ERR_SHOW_LEN(ERR_SHOW_LEN)) i_dtl_command_core_properties (
  .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .seqInitDone(seqInitDone), .panelLocked(panelLocked), .lockLed(lockLed),
  .recallStep(recallStep), .seqStart(seqStart), .errShow(errShow), .errCode(errCode));

// [verification/dtl_host_model.sv]
`timescale 1ns/1ns
module dtl_host_model (
  input wire logic sys_clk, // Clock
  input wire logic ack, // Slave acknowledge
  input wire logic [31:0] datR, // Read data
  output logic cyc, // Cycle
  output logic stb, // Strobe
  output logic we, // Write enable
  output logic [7:0] adr, // Byte address
  output logic [3:0] sel, // Byte lanes
  output logic [31:0] datW // Write data
);
  initial begin
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; datW = 32'h0;
  end
  // Called just after a rising edge; holds the request until ack is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; datW <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = datR;
    // Released data lines toggle so a stale value is never mistaken for a live one
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; datW <= ~d;
    @(posedge sys_clk);
  endtask
endmodule

// [verification/dwell_trigger_limit_commands_test.sv]
`timescale 1ns/1ns
module dwell_trigger_limit_commands_test
  import dtl_pkg::*;
;
  logic sys_clk, reset_n, trigPin, analogModePin, seqInitDone, seqBusy, cyc, stb, we, ack;
  logic panelLocked, lockLed, outputOn, recallStep, seqStart, errShow;
  logic [7:0] adr, errCode;
  logic [3:0] sel;
  logic [31:0] datW, datR, rdat;
  logic [19:0] analogSetpointMv, voltSetpointMv, limitDisplayMv;
  logic signed [19:0] measVoltMv;
  int mismatches, nChecks, m, k;
  dtl_command_core #(.ERR_SHOW_LEN(20)) i_dtl_command_core (.sys_clk(sys_clk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
    .wb_ack_o(ack), .wb_dat_o(datR), .trigPin(trigPin), .analogModePin(analogModePin),
    .analogSetpointMv(analogSetpointMv), .measVoltMv(measVoltMv), .seqInitDone(seqInitDone),
    .seqBusy(seqBusy), .panelLocked(panelLocked), .lockLed(lockLed), .outputOn(outputOn),
    .recallStep(recallStep), .seqStart(seqStart), .errShow(errShow), .errCode(errCode),
    .voltSetpointMv(voltSetpointMv), .limitDisplayMv(limitDisplayMv));
  dtl_host_model i_dtl_host_model (.sys_clk(sys_clk), .ack(ack), .datR(datR), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .datW(datW));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input dtl_op_t op, input logic [31:0] arg);
    i_dtl_host_model.xfer(1'b1, OFS_ARG, arg, rdat);
    i_dtl_host_model.xfer(1'b1, OFS_CMD, {28'h0, op}, rdat);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    i_dtl_host_model.xfer(1'b0, a, 32'h0, rdat);
    chk(rdat, e);
  endtask
  // Reads one character past the end to prove the length is exact
  task automatic query(input dtl_op_t op, input logic [103:0] exp, input int n);
    int i;
    i_dtl_host_model.xfer(1'b1, OFS_CMD, {28'h0, op}, rdat);
    for (i = 0; i <= n; i++) begin
      i_dtl_host_model.xfer(1'b0, OFS_RESP, 32'h0, rdat);
      chk(rdat, (i < n) ? {24'h0, exp[8*(n-1-i)+:8]} : 32'h0);
    end
  endtask
  task automatic clr();
    i_dtl_host_model.xfer(1'b1, OFS_EVB, 32'hff, rdat);
    i_dtl_host_model.xfer(1'b1, OFS_STDEV, 32'hff, rdat);
  endtask
  function automatic logic [23:0] chName(input int c);
    case (c)
      0: return TXT_CH_OFF;
      1: return TXT_CH_OUT;
      2: return TXT_CH_RECALL;
      3: return TXT_CH_SEQRUN;
      4: return TXT_CH_LOCK;
      default: return TXT_CH_MINMAX;
    endcase
  endfunction
  task automatic stop_test();
    if (mismatches == 0 && nChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog, tests
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    reset_n = 1'b0; trigPin = 1'b0; analogModePin = 1'b0; seqInitDone = 1'b0; seqBusy = 1'b0;
    analogSetpointMv = 20'h03a98; measVoltMv = 20'sh06b6c; mismatches = 0; nChecks = 0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    query(OP_Q_DWELL_LOC, {TXT_DWELL_LOC, " 00.00"}, 10);
    query(OP_Q_DWELL_DEF, {TXT_DWELL_DEF, " 01.00"}, 10);
    cmd(OP_SET_DWELL_DEF, 32'h0000270f);
    cmd(OP_SET_DWELL_DEF, 32'h00002710);
    rchk(OFS_STDEV, 32'h00000020);
    clr();
    cmd(OP_SET_DWELL_LOC, 32'h00000002);
    query(OP_Q_DWELL_LOC, {TXT_DWELL_LOC, " 00.02"}, 10);
    cmd(OP_RESET, 32'h0);
    query(OP_Q_DWELL_DEF, {TXT_DWELL_DEF, " 99.99"}, 10);
    query(OP_Q_DWELL_LOC, {TXT_DWELL_LOC, " 00.00"}, 10);
    cmd(OP_SET_POINT, 32'h00b71b00);
    cmd(OP_SET_LIMIT, 32'h00b71718);
    rchk(OFS_EVB, 32'h00000002);
    rchk(OFS_STDEV, 32'h00000010);
    query(OP_Q_LIMIT, {TXT_LIMIT, " +020.000"}, 13);
    clr();
    cmd(OP_SET_LIMIT, 32'h00bc609c);
    query(OP_Q_LIMIT, {TXT_LIMIT, " +012.346"}, 13);
    chk({12'h0, limitDisplayMv}, 32'h0000303e);
    cmd(OP_SET_POINT, 32'h00c65d40);
    rchk(OFS_EVB, 32'h00000002);
    chk({12'h0, voltSetpointMv}, 32'h00002ee0);
    analogModePin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk({12'h0, voltSetpointMv}, 32'h00003a98);
    analogModePin <= 1'b0;
    clr();
    for (m = 0; m < 6; m++) begin
      cmd(OP_SET_TRIG, 32'(m));
      query(OP_Q_TRIG, {TXT_TRIG, " ", chName(m)}, 10);
    end
    measVoltMv <= 20'sd28125;
    trigPin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    measVoltMv <= 20'sd27350;
    repeat (6) @(posedge sys_clk);
    trigPin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // Trigger low in min-max control: this dip must not reach the floor
    measVoltMv <= 20'sd1;
    query(OP_Q_PEAK, {TXT_PEAK, " +028.125"}, 13);
    query(OP_Q_FLOOR, {TXT_FLOOR, " +027.350"}, 13);
    cmd(OP_SET_TRIG, 32'h4);
    chk({30'h0, panelLocked, lockLed}, 32'h3);
    cmd(OP_SAVE, 32'h0);
    rchk(OFS_SAVED, 32'h0000303a);
    cmd(OP_SET_TRIG, 32'h1);
    trigPin <= 1'b1;
    seqBusy <= 1'b1;
    repeat (6) @(posedge sys_clk);
    trigPin <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({29'h0, panelLocked, lockLed, outputOn}, 32'h3);
    seqBusy <= 1'b0;
    cmd(OP_SET_TRIG, 32'h2);
    trigPin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({23'h0, errShow, errCode}, {23'h0, 1'b1, ERR_CODE_SEQ});
    trigPin <= 1'b0;
    repeat (30) @(posedge sys_clk);
    rchk(OFS_EVB, 32'h00000020);
    seqInitDone <= 1'b1;
    // Step recall, then sequence run, each gives exactly one pulse once initialised
    for (m = 2; m < 4; m++) begin
      cmd(OP_SET_TRIG, 32'(m));
      trigPin <= 1'b1;
      k = 0;
      repeat (8) begin
        @(posedge sys_clk);
        if (((m == 2) ? recallStep : seqStart) === 1'b1) k++;
      end
      trigPin <= 1'b0;
      chk(32'(k), 32'h1);
      repeat (4) @(posedge sys_clk);
    end
    stop_test();
  end
endmodule
